// File: hdl/ptfu_pkg.sv
package ptfu_pkg;

    localparam int DW    = 36;
    localparam int AW    = 32;
    localparam int CW    = 4;
    localparam int BW    = 3;
    localparam int SW    = 3;
    localparam int DEPTH = 2;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;

    // Control fields
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam logic CTRL_EN_RST = 1'b1;

    // Status fields
    localparam int STAT_WVLD_BIT = 0;
    localparam int STAT_RFULL_BIT = 1;
    localparam int STAT_REQ_BIT  = 2;
    localparam int STAT_RDY_BIT  = 3;
    localparam int STAT_ST_LSB   = 4;
    localparam int STAT_WCNT_LSB = 8;
    localparam int STAT_RCNT_LSB = 10;
    localparam int STAT_QCNT_LSB = 12;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_ADDR    = 3'h1,
        ST_ADDR_HI = 3'h3,
        ST_WDATA   = 3'h2,
        ST_RDATA   = 3'h6,
        ST_CLEAR   = 3'h4
    } ptfu_state_t;

    // One queued PCI target request
    typedef struct packed {
        logic [AW-1:0] addr_hi;
        logic [AW-1:0] addr_lo;
        logic [CW-1:0] cmd;
        logic [BW-1:0] bar;
        logic          wide;
    } ptfu_req_t;

endpackage

// File: hdl/ptfu_target_port.sv
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps

module ptfu_fifo2 #(
    parameter int W = 36
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clr,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    input  wire logic         out_ready,
    output logic              in_ready,
    output logic              out_valid,
    output logic              out_empty,
    output logic [W-1:0]      out_data,
    output logic [1:0]        count
);
    localparam int D = ptfu_pkg::DEPTH;

    logic [1:0]   cnt_r;
    logic [1:0]   cnt_nxt;
    logic [W-1:0] mem_r [D];

    wire       push = in_valid && in_ready;
    wire       pop  = out_ready && out_valid;
    wire [1:0] base = cnt_r - {1'b0, pop};

    // Clear wins over a push in the same cycle
    assign cnt_nxt  = clr ? 2'h0 : base + {1'b0, push};
    assign out_data = mem_r[0];
    assign count    = cnt_r;

    // Head is always entry 0; a pop shifts the queue down
    for (genvar i = 0; i < D; i++) begin : g_ent
        wire [W-1:0] kept;
        if (i + 1 < D) begin : g_sh
            assign kept = pop ? mem_r[i+1] : mem_r[i];
        end else begin : g_last
            assign kept = mem_r[i];
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mem_r[i] <= '0;
            end else if (push && base == 2'(i)) begin
                mem_r[i] <= in_data;
            end else begin
                mem_r[i] <= kept;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r     <= 2'h0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            out_empty <= 1'b1;
        end else begin
            cnt_r     <= cnt_nxt;
            in_ready  <= cnt_nxt != 2'(D);
            out_valid <= cnt_nxt != 2'h0;
            out_empty <= cnt_nxt == 2'h0;
        end
    end

endmodule // ptfu_fifo2

module ptfu_target_port (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     pci_rst_n,
    input  wire logic                     pci_wr_valid,
    input  wire logic [ptfu_pkg::DW-1:0]  pci_wr_data,
    output logic                          pci_wr_ready,
    input  wire logic                     pci_req_valid,
    input  wire ptfu_pkg::ptfu_req_t      pci_req,
    output logic                          pci_req_ready,
    output logic                          pci_rd_valid,
    output logic [ptfu_pkg::DW-1:0]       pci_rd_data,
    input  wire logic                     pci_rd_ready,
    input  wire logic                     tgt_queue_clear_n,
    output logic                          tgt_req_n,
    output logic                          tgt_ready,
    input  wire logic                     addr_oe_n,
    input  wire logic                     wr_data_en_n,
    output logic [ptfu_pkg::DW-1:0]       wr_data,
    output logic                          wr_fifo_empty_n,
    input  wire logic                     rd_data_en_n,
    input  wire logic [ptfu_pkg::DW-1:0]  rd_data,
    output logic                          rd_fifo_full_n,
    output logic [ptfu_pkg::CW-1:0]       tgt_cmd,
    output logic [ptfu_pkg::BW-1:0]       tgt_bar,
    output logic [ptfu_pkg::SW-1:0]       tgt_state
);
    localparam int QW = $bits(ptfu_pkg::ptfu_req_t);

    ptfu_pkg::ptfu_state_t   state_r;
    ptfu_pkg::ptfu_state_t   state_nxt;
    ptfu_pkg::ptfu_req_t     req_in;
    ptfu_pkg::ptfu_req_t     req_head;
    logic [ptfu_pkg::DW-1:0] wf_head;
    logic [ptfu_pkg::DW-1:0] wr_data_r;
    logic                    en_r;
    logic                    soft_clr_r;
    logic                    is_write_r;
    logic                    wf_vld;
    logic                    wf_empty;
    logic                    rf_rdy;
    logic                    rf_empty;
    logic                    q_vld;
    logic                    q_empty;
    logic [1:0]              wf_cnt;
    logic [1:0]              rf_cnt;
    logic [1:0]              q_cnt;
    logic                    ready_r;

    wire clr       = !tgt_queue_clear_n || soft_clr_r || !pci_rst_n;
    wire start     = state_r == ptfu_pkg::ST_IDLE && !addr_oe_n && q_vld;
    wire hi_cycle  = state_r == ptfu_pkg::ST_ADDR && !addr_oe_n;
    wire q_pop     = (start && !req_head.wide) || (hi_cycle && req_head.wide);
    wire addr_busy = start || hi_cycle;
    wire wf_pop    = !wr_data_en_n && wf_vld && !addr_busy && !clr;
    wire rf_push   = !rd_data_en_n;
    wire cmd_write = req_head.cmd[0];

    // Wide BARs use the even number of the pair
    always_comb begin
        req_in = pci_req;
        if (pci_req.wide) begin
            req_in.bar = {pci_req.bar[ptfu_pkg::BW-1:1], 1'b0};
        end
    end

    // Target write FIFO toward the user
    ptfu_fifo2 #(.W(ptfu_pkg::DW)) u_wfifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .clr       (clr),
        .in_valid  (pci_wr_valid),
        .in_data   (pci_wr_data),
        .out_ready (wf_pop),
        .in_ready  (pci_wr_ready),
        .out_valid (wf_vld),
        .out_empty (wf_empty),
        .out_data  (wf_head),
        .count     (wf_cnt)
    );

    // Target read FIFO from the user
    ptfu_fifo2 #(.W(ptfu_pkg::DW)) u_rfifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .clr       (clr),
        .in_valid  (rf_push),
        .in_data   (rd_data),
        .out_ready (pci_rd_ready),
        .in_ready  (rf_rdy),
        .out_valid (pci_rd_valid),
        .out_empty (rf_empty),
        .out_data  (pci_rd_data),
        .count     (rf_cnt)
    );

    // Address and command queue; a clear drops it too
    ptfu_fifo2 #(.W(QW)) u_queue (
        .pclk      (pclk),
        .presetn   (presetn),
        .clr       (clr),
        .in_valid  (pci_req_valid),
        .in_data   (req_in),
        .out_ready (q_pop),
        .in_ready  (pci_req_ready),
        .out_valid (q_vld),
        .out_empty (q_empty),
        .out_data  (req_head),
        .count     (q_cnt)
    );

    assign tgt_req_n       = q_empty;
    assign tgt_cmd         = req_head.cmd;
    assign tgt_bar         = req_head.bar;
    assign wr_fifo_empty_n = wf_vld;
    assign rd_fifo_full_n  = rf_rdy;
    assign wr_data         = wr_data_r;
    assign tgt_state       = state_r;
    assign tgt_ready       = ready_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ptfu_pkg::ST_IDLE: begin
                if (start) begin
                    state_nxt = req_head.wide ? ptfu_pkg::ST_ADDR
                              : (cmd_write ? ptfu_pkg::ST_WDATA : ptfu_pkg::ST_RDATA);
                end
            end
            ptfu_pkg::ST_ADDR: begin
                if (hi_cycle) begin
                    state_nxt = ptfu_pkg::ST_ADDR_HI;
                end
            end
            ptfu_pkg::ST_ADDR_HI: begin
                state_nxt = is_write_r ? ptfu_pkg::ST_WDATA : ptfu_pkg::ST_RDATA;
            end
            ptfu_pkg::ST_WDATA: begin
                if (!wf_vld) begin
                    state_nxt = ptfu_pkg::ST_IDLE;
                end
            end
            ptfu_pkg::ST_RDATA: begin
                if (rf_push) begin
                    state_nxt = ptfu_pkg::ST_IDLE;
                end
            end
            ptfu_pkg::ST_CLEAR: begin
                state_nxt = ptfu_pkg::ST_IDLE;
            end
            default: state_nxt = ptfu_pkg::ST_IDLE;
        endcase
        if (clr) begin
            state_nxt = ptfu_pkg::ST_CLEAR;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= ptfu_pkg::ST_IDLE;
            is_write_r <= 1'b0;
            ready_r    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            is_write_r <= start ? cmd_write : is_write_r;
            ready_r    <= !clr && en_r;
        end
    end

    // Shared user data path: address words first, then write data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_data_r <= '0;
        end else if (start) begin
            wr_data_r <= {req_head.cmd, req_head.addr_lo};
        end else if (hi_cycle) begin
            wr_data_r <= {req_head.cmd, req_head.addr_hi};
        end else if (wf_pop) begin
            wr_data_r <= wf_head;
        end
    end

    // APB slave: one wait state, answer on the second access cycle
    wire       apb_acc = psel && penable;
    wire       apb_end = apb_acc && pready;
    wire       hit_ctl = paddr == ptfu_pkg::CTRL_OFS;
    wire       hit_st  = paddr == ptfu_pkg::STAT_OFS;
    wire       ctl_wr  = apb_end && pwrite && hit_ctl;
    wire [31:0] ctl_word = {30'h0, 1'b0, en_r};
    wire [31:0] st_word  = {18'h0, q_cnt, rf_cnt, wf_cnt, 1'b0, state_r,
                            ready_r, !q_empty, !rf_rdy, wf_vld};
    wire [31:0] rd_word  = hit_ctl ? ctl_word : (hit_st ? st_word : ptfu_pkg::ZERO_WORD);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h0000_0000;
            en_r       <= ptfu_pkg::CTRL_EN_RST;
            soft_clr_r <= 1'b0;
        end else begin
            pready     <= apb_acc && !pready;
            pslverr    <= apb_acc && !pready && !hit_ctl && !hit_st;
            prdata     <= (apb_acc && !pready && !pwrite) ? rd_word : prdata;
            en_r       <= ctl_wr ? pwdata[ptfu_pkg::CTRL_EN_BIT] : en_r;
            soft_clr_r <= ctl_wr && pwdata[ptfu_pkg::CTRL_CLR_BIT];
        end
    end

    // Checks
    chk_req_follows: assert property (@(posedge pclk) disable iff (!presetn)
        (pci_req_valid && pci_req_ready && !clr) |=> !tgt_req_n)
        else $error("request not raised after a queued transfer");

    chk_req_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (q_cnt != 2'h0) |-> !tgt_req_n)
        else $error("request dropped while queue holds an address");

    chk_clear_empties: assert property (@(posedge pclk) disable iff (!presetn)
        clr |=> (!wr_fifo_empty_n && tgt_req_n && !pci_rd_valid))
        else $error("clear left a target FIFO nonempty");

    chk_ready_low: assert property (@(posedge pclk) disable iff (!presetn)
        (!pci_rst_n || !tgt_queue_clear_n) |=> !tgt_ready)
        else $error("ready high during reset or clear");

    chk_bar_even: assert property (@(posedge pclk) disable iff (!presetn)
        (!tgt_req_n && req_head.wide) |-> !tgt_bar[0])
        else $error("wide BAR reported with odd number");

    chk_addr_word: assert property (@(posedge pclk) disable iff (!presetn)
        (start && !clr) |=> wr_data[31:0] == $past(req_head.addr_lo))
        else $error("address word missing on data path");

    chk_addr_cycles: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ptfu_pkg::ST_ADDR_HI && !clr) |=> state_r inside {ptfu_pkg::ST_WDATA, ptfu_pkg::ST_RDATA})
        else $error("extra address cycle issued");

    chk_wr_advance: assert property (@(posedge pclk) disable iff (!presetn)
        wf_pop |=> (wr_data == $past(wf_head)) ##1
            ($stable(wr_data) || !$past(wr_data_en_n) || !$past(addr_oe_n)))
        else $error("write FIFO word not delivered");

    chk_empty_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (wf_cnt == 2'h0 && pci_wr_valid && !clr) |=> wr_fifo_empty_n)
        else $error("empty flag stuck after a write word");

    chk_state_legal: assert property (@(posedge pclk) disable iff (!presetn)
        tgt_state inside {3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4})
        else $error("illegal state counter value");

endmodule // ptfu_target_port

// File: tb/ptfu_target_port_tb.sv
`timescale 1ns/1ps
module ptfu_target_port_tb;
    logic                pclk = 1'b0;
    logic                presetn = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [7:0]          paddr = 8'h00;
    logic [31:0]         pwdata = 32'h0000_0000;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                pci_rst_n = 1'b1;
    logic                pci_wr_valid = 1'b0;
    logic [35:0]         pci_wr_data = 36'h0_0000_0000;
    logic                pci_wr_ready;
    logic                pci_req_valid = 1'b0;
    ptfu_pkg::ptfu_req_t pci_req = '0;
    logic                pci_req_ready;
    logic                pci_rd_valid;
    logic [35:0]         pci_rd_data;
    logic                pci_rd_ready = 1'b0;
    logic                clr_n;
    logic                req_n;
    logic                tgt_ready;
    logic                aoe_n;
    logic                wen_n;
    logic [35:0]         wr_data;
    logic                empty_n;
    logic                ren_n;
    logic [35:0]         rd_data;
    logic                full_n;
    logic [3:0]          tgt_cmd;
    logic [2:0]          tgt_bar;
    logic [2:0]          tgt_state;
    logic [35:0]         w0;
    logic [35:0]         w1;
    logic [31:0]         rd;
    logic                er;
    int                  fail_count = 0;
    int                  comparisons = 0;

    always #4 pclk = ~pclk;

    ptfu_target_port u_ptfu_target_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pci_rst_n(pci_rst_n), .pci_wr_valid(pci_wr_valid), .pci_wr_data(pci_wr_data),
        .pci_wr_ready(pci_wr_ready), .pci_req_valid(pci_req_valid), .pci_req(pci_req),
        .pci_req_ready(pci_req_ready), .pci_rd_valid(pci_rd_valid), .pci_rd_data(pci_rd_data),
        .pci_rd_ready(pci_rd_ready), .tgt_queue_clear_n(clr_n), .tgt_req_n(req_n), .tgt_ready(tgt_ready),
        .addr_oe_n(aoe_n), .wr_data_en_n(wen_n), .wr_data(wr_data), .wr_fifo_empty_n(empty_n),
        .rd_data_en_n(ren_n), .rd_data(rd_data), .rd_fifo_full_n(full_n), .tgt_cmd(tgt_cmd),
        .tgt_bar(tgt_bar), .tgt_state(tgt_state));

    ptfu_user_model u_ptfu_user_model (.pclk(pclk), .wr_data(wr_data), .tgt_queue_clear_n(clr_n),
        .addr_oe_n(aoe_n), .wr_data_en_n(wen_n), .rd_data_en_n(ren_n), .rd_data(rd_data));

    task automatic chk(input logic [35:0] act, input logic [35:0] exp);
        comparisons++;
        if (act !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr_push(input logic [35:0] d);
        @(posedge pclk);
        pci_wr_valid <= 1'b1;
        pci_wr_data <= d;
        do @(posedge pclk); while (pci_wr_ready !== 1'b1);
        pci_wr_valid <= 1'b0;
    endtask
    task automatic req_push(input ptfu_pkg::ptfu_req_t r);
        @(posedge pclk);
        pci_req_valid <= 1'b1;
        pci_req <= r;
        do @(posedge pclk); while (pci_req_ready !== 1'b1);
        pci_req_valid <= 1'b0;
    endtask
    task automatic t_regs();
        #1 chk(36'(req_n), 36'h1);
        chk(36'(empty_n), 36'h0);
        chk(36'(tgt_state), 36'h0);
        apb(1'b0, ptfu_pkg::CTRL_OFS, 32'h0);
        chk(36'(rd), 36'h1);
        apb(1'b0, ptfu_pkg::STAT_OFS, 32'h0);
        chk(36'(rd), 36'h8);
        apb(1'b0, 8'h08, 32'h0);
        chk(36'({er, rd}), 36'h1_0000_0000);
        apb(1'b1, ptfu_pkg::CTRL_OFS, 32'h0);
        for (int n = 0; n < 8 && tgt_ready !== 1'b0; n++) @(posedge pclk);
        chk(36'(tgt_ready), 36'h0);
        apb(1'b1, ptfu_pkg::CTRL_OFS, 32'h1);
        $display("regs test done");
    endtask
    task automatic t_wdata();
        wr_push(36'hA_1111_0001);
        wr_push(36'h5_2222_0002);
        #1 chk(36'(pci_wr_ready), 36'h0);
        chk(36'(empty_n), 36'h1);
        apb(1'b0, ptfu_pkg::STAT_OFS, 32'h0);
        chk(36'(rd & 32'h0000_0F0F), 36'h209);
        u_ptfu_user_model.take(1'b0, 2, w0, w1);
        chk(w0, 36'hA_1111_0001);
        chk(w1, 36'h5_2222_0002);
        chk(36'(empty_n), 36'h0);
        u_ptfu_user_model.take(1'b0, 1, w0, w1);
        chk(w0, 36'h5_2222_0002);
        $display("write data test done");
    endtask
    task automatic t_req();
        req_push('{32'h0, 32'h1234_5678, 4'h7, 3'h5, 1'b0});
        req_push('{32'h0000_00AB, 32'h8000_0000, 4'h6, 3'h4, 1'b1});
        #1 chk(36'(pci_req_ready), 36'h0);
        for (int n = 0; n < 8 && req_n !== 1'b0; n++) @(posedge pclk);
        chk(36'({tgt_cmd, tgt_bar}), 36'h3D);
        u_ptfu_user_model.take(1'b1, 1, w0, w1);
        chk(w0, 36'h7_1234_5678);
        chk(36'(tgt_state), 36'(ptfu_pkg::ST_WDATA));
        @(posedge pclk);
        #1 chk(36'({req_n, tgt_cmd, tgt_bar}), 36'h34);
        u_ptfu_user_model.take(1'b1, 2, w0, w1);
        chk(w0, 36'h6_8000_0000);
        chk(w1, 36'h6_0000_00AB);
        for (int n = 0; n < 8 && req_n !== 1'b1; n++) @(posedge pclk);
        chk(36'(req_n), 36'h1);
        $display("request test done");
    endtask
    task automatic t_rdata();
        u_ptfu_user_model.push(36'hC_0000_00C3);
        u_ptfu_user_model.push(36'h3_FFFF_FF3C);
        #1 chk(36'(full_n), 36'h0);
        chk(pci_rd_data, 36'hC_0000_00C3);
        for (int i = 0; i < 2; i++) begin
            @(posedge pclk);
            pci_rd_ready <= 1'b1;
            @(posedge pclk);
            pci_rd_ready <= 1'b0;
            #1 chk(36'({pci_rd_valid, full_n}), i == 0 ? 36'h3 : 36'h1);
            if (i == 0) chk(pci_rd_data, 36'h3_FFFF_FF3C);
        end
        req_push('{32'h0000_0001, 32'h0000_0100, 4'h7, 3'h3, 1'b1});
        #1 chk(36'({tgt_cmd, tgt_bar}), 36'h3A);
        u_ptfu_user_model.take(1'b1, 2, w0, w1);
        chk(w0, 36'h7_0000_0100);
        chk(w1, 36'h7_0000_0001);
        @(posedge pclk);
        #1 chk(36'(tgt_state), 36'(ptfu_pkg::ST_WDATA));
        $display("read data test done");
    endtask
    task automatic t_clear();
        wr_push(36'h0_0000_00EE);
        req_push('{32'h0, 32'h0000_0040, 4'h2, 3'h1, 1'b0});
        u_ptfu_user_model.clear();
        #1 chk(36'({empty_n, req_n, tgt_ready}), 36'h2);
        chk(36'(tgt_state), 36'(ptfu_pkg::ST_CLEAR));
        for (int n = 0; n < 8 && tgt_ready !== 1'b1; n++) @(posedge pclk);
        #1 chk(36'({tgt_ready, req_n, tgt_state}), 36'h18);
        @(posedge pclk);
        pci_rst_n <= 1'b0;
        for (int n = 0; n < 8 && tgt_ready !== 1'b0; n++) @(posedge pclk);
        chk(36'(tgt_ready), 36'h0);
        pci_rst_n <= 1'b1;
        for (int n = 0; n < 8 && tgt_ready !== 1'b1; n++) @(posedge pclk);
        chk(36'(tgt_ready), 36'h1);
        wr_push(36'h0_0000_0077);
        apb(1'b1, ptfu_pkg::CTRL_OFS, 32'h3);
        for (int n = 0; n < 8 && empty_n !== 1'b0; n++) @(posedge pclk);
        chk(36'(empty_n), 36'h0);
        apb(1'b0, ptfu_pkg::CTRL_OFS, 32'h0);
        chk(36'(rd), 36'h1);
        $display("clear test done");
    endtask
    task automatic results();
        $display("%0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #20000;
        fail_count++;
        $display("CHECK FAILED at %0t: timeout", $time);
        results();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_wdata();
        t_req();
        t_rdata();
        t_clear();
        results();
    end
endmodule // ptfu_target_port_tb

// File: tb/ptfu_user_model.sv
`timescale 1ns/1ps
// User logic on the fabric side: every strobe is changed just after a clock edge
module ptfu_user_model (
    input  wire logic        pclk,
    input  wire logic [35:0] wr_data,
    output logic             tgt_queue_clear_n,
    output logic             addr_oe_n,
    output logic             wr_data_en_n,
    output logic             rd_data_en_n,
    output logic [35:0]      rd_data
);
    initial begin
        tgt_queue_clear_n = 1'b1;
        addr_oe_n = 1'b1;
        wr_data_en_n = 1'b1;
        rd_data_en_n = 1'b1;
        rd_data = 36'h0_0000_0000;
    end
    // Holds the enable for n edges and samples the word after each
    task automatic take(input logic adr, input int n, output logic [35:0] w0, output logic [35:0] w1);
        @(posedge pclk);
        if (adr) addr_oe_n <= 1'b0;
        else wr_data_en_n <= 1'b0;
        @(posedge pclk);
        if (n == 1) addr_oe_n <= 1'b1;
        if (n == 1) wr_data_en_n <= 1'b1;
        #1 w0 = wr_data;
        w1 = w0;
        if (n == 2) begin
            @(posedge pclk);
            addr_oe_n <= 1'b1;
            wr_data_en_n <= 1'b1;
            #1 w1 = wr_data;
        end
    endtask
    task automatic push(input logic [35:0] d);
        @(posedge pclk);
        rd_data_en_n <= 1'b0;
        rd_data <= d;
        @(posedge pclk);
        rd_data_en_n <= 1'b1;
        rd_data <= ~d;
    endtask
    task automatic clear();
        @(posedge pclk);
        tgt_queue_clear_n <= 1'b0;
        @(posedge pclk);
        tgt_queue_clear_n <= 1'b1;
    endtask
endmodule // ptfu_user_model
